/* File: node_address_decode.sv */
// Address decode and local control of a processor node board.
// Assumes processor bus cycles synchronous to i_clock, one at a time,
// with the register port as a plain single-cycle master.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Sixteen 256 MB blocks by top nibble
// - At most one data bus driver
// - Reset clears all control bits
// - Boot bit zero maps EPROM high
// - EPROM aliases every 64 KB section
// - Boot bit set unmaps EPROM until reset
// - F0-F7 always on-board DRAM
// - Block E is cached DRAM
// - Block D is uncached DRAM
// - Cache allow decoded straight from address
// - DRAM repeats modulo 8 or 32 MB
// - Serial and local ports use whole blocks
// - FIFO write halves: data, end of message
// - FIFO reads pop alike in block
// - Refresh defeat suppresses refresh
// - Force parity blocks parity memory access
// - Wrap mode loops transmit into receive
// - Writes get one wait state
// - Interrupt sources gated by mask bits
// - Counter advances every 100 ns
module node_address_decode
(
  input wire logic i_clock,           // System clock
  input wire logic i_reset,           // Async reset, high
  input wire logic i_cpu_start,       // Bus cycle start strobe
  input wire logic i_cpu_write,       // Cycle is a write
  input wire logic [31:0] i_cpu_addr, // Bus address
  input wire logic i_dram_large,      // Larger DRAM parts fitted
  input wire logic [3:0] i_irq_src,   // Raw interrupt sources
  input wire logic i_refresh_req,     // Refresh timer request
  input wire logic i_tx_word_valid,   // Word leaving transmit FIFO
  input wire logic [3:0] i_reg_addr,  // Register port address
  input wire logic [31:0] i_reg_wdata,// Register write data
  input wire logic i_reg_write,       // Register write strobe
  input wire logic i_reg_read,        // Register read strobe
  output logic [31:0] o_reg_rdata,    // Register read data
  output logic o_ready,               // Bus cycle complete
  output logic o_sel_eprom,           // EPROM select
  output logic o_sel_dram,            // DRAM select
  output logic o_sel_fifo,            // Network FIFO select
  output logic o_sel_status,          // Status port select
  output logic o_sel_ctrl_counter,    // Control port/counter select
  output logic o_sel_serial,          // Serial port select
  output logic o_sel_none,            // Nothing selected
  output logic [15:0] o_eprom_addr,   // EPROM offset
  output logic [24:0] o_dram_addr,    // DRAM offset
  output logic o_cache_allow_n,       // Cache enable, low active
  output logic o_fifo_push,           // Transmit FIFO push
  output logic o_fifo_end_of_message, // Push flagged end of message
  output logic o_fifo_pop,            // Receive FIFO pop
  output logic o_refresh_go,          // Refresh cycle issue
  output logic o_parity_enable,       // Parity memory access allow
  output logic o_tx_to_net,           // Transmit word to network
  output logic o_tx_to_rx,            // Transmit word looped back
  output logic o_irq                  // Masked interrupt
);

  logic [15:0] ctrl_reg;     // Control register
  logic [3:0] blk;           // Top address nibble
  logic top_half;            // Upper half of block
  logic boot_mapped;         // EPROM currently mapped
  logic dec_eprom;           // Combinational selects
  logic dec_dram;
  logic dec_fifo;
  logic dec_status;
  logic dec_ctrl_counter;
  logic dec_serial;
  logic [31:0] cyc_addr_reg; // Address held for the cycle
  logic cyc_write_reg;       // Write held for the cycle
  logic [1:0] wait_reg;      // Wait states left
  node_decode_pkg::bus_state_t state_reg; // Bus cycle state
  logic tick;                // Counter tick
  logic [node_decode_pkg::COUNT_W-1:0] count; // Counter value
  logic [3:0] irq_mask;      // Mask bits from control

  // Counter tick and counter
  node_tick_gen u_tick
  (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .o_tick (tick)
  );

  node_counter u_count
  (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_tick (tick),
    .o_count (count)
  );

  // Control register, software written
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      ctrl_reg <= node_decode_pkg::CTL_RESET;
    else if (i_reg_write && i_reg_addr == node_decode_pkg::REG_CTRL)
    begin
      ctrl_reg <= i_reg_wdata[15:0];
      // Boot bit is sticky once set
      if (ctrl_reg[node_decode_pkg::CTL_BOOT_OFF])
        ctrl_reg[node_decode_pkg::CTL_BOOT_OFF] <= 1'b1;
    end
  end

  assign boot_mapped = ~ctrl_reg[node_decode_pkg::CTL_BOOT_OFF];
  assign irq_mask = ctrl_reg[node_decode_pkg::CTL_MASK_LO +:
                             node_decode_pkg::CTL_MASK_W];

  // Bus cycle: latch address, count write waits
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg <= node_decode_pkg::BUS_IDLE;
      cyc_addr_reg <= 32'h00000000;
      cyc_write_reg <= 1'b0;
      wait_reg <= 2'h0;
    end
    else
    begin
      unique case (state_reg)
        node_decode_pkg::BUS_IDLE:
        begin
          if (i_cpu_start)
          begin
            cyc_addr_reg <= i_cpu_addr;
            cyc_write_reg <= i_cpu_write;
            // Writes wait for parity generation
            if (i_cpu_write)
            begin
              wait_reg <= 2'(node_decode_pkg::WRITE_WAITS);
              state_reg <= node_decode_pkg::BUS_WAIT;
            end
            else
              state_reg <= node_decode_pkg::BUS_DONE;
          end
        end
        node_decode_pkg::BUS_WAIT:
        begin
          // Burn the wait states
          if (wait_reg == 2'h1)
            state_reg <= node_decode_pkg::BUS_DONE;
          wait_reg <= wait_reg - 2'h1;
        end
        node_decode_pkg::BUS_DONE:
          state_reg <= node_decode_pkg::BUS_IDLE;
      endcase
    end
  end

  assign blk = cyc_addr_reg[31:28];
  assign top_half = cyc_addr_reg[node_decode_pkg::TOP_HALF_BIT];

  // Block decode; each block yields at most one select
  always_comb
  begin
    dec_eprom = 1'b0;
    dec_dram = 1'b0;
    dec_fifo = 1'b0;
    dec_status = 1'b0;
    dec_ctrl_counter = 1'b0;
    dec_serial = 1'b0;
    if (state_reg != node_decode_pkg::BUS_IDLE)
    begin
      unique case (blk)
        node_decode_pkg::BLK_TOP:
        begin
          // Upper half goes to EPROM while boot mapped
          if (top_half && boot_mapped)
            dec_eprom = 1'b1;
          else
            dec_dram = 1'b1;
        end
        node_decode_pkg::BLK_DRAM: dec_dram = 1'b1;
        node_decode_pkg::BLK_DRAM_NC: dec_dram = 1'b1;
        node_decode_pkg::BLK_FIFO: dec_fifo = 1'b1;
        node_decode_pkg::BLK_STATUS: dec_status = 1'b1;
        node_decode_pkg::BLK_CTRL_COUNTER: dec_ctrl_counter = 1'b1;
        node_decode_pkg::BLK_SERIAL: dec_serial = 1'b1;
        default: ; // Unused blocks left free
      endcase
    end
  end

  // Selects and offsets
  assign o_sel_eprom = dec_eprom;
  assign o_sel_dram = dec_dram;
  assign o_sel_fifo = dec_fifo;
  assign o_sel_status = dec_status;
  assign o_sel_ctrl_counter = dec_ctrl_counter;
  assign o_sel_serial = dec_serial;
  assign o_sel_none = (state_reg != node_decode_pkg::BUS_IDLE) &&
    !(dec_eprom | dec_dram | dec_fifo | dec_status |
      dec_ctrl_counter | dec_serial);
  assign o_eprom_addr = cyc_addr_reg[node_decode_pkg::EPROM_AW-1:0];
  assign o_dram_addr = i_dram_large ?
    cyc_addr_reg[node_decode_pkg::DRAM_AW_LARGE-1:0] :
    {2'b00, cyc_addr_reg[node_decode_pkg::DRAM_AW_SMALL-1:0]};
  assign o_ready = (state_reg == node_decode_pkg::BUS_DONE);

  // Cache allow straight off the live address, not pipelined
  assign o_cache_allow_n = (i_cpu_addr[31:28] == node_decode_pkg::BLK_DRAM_NC)
    ? 1'b1 : 1'b0;

  // FIFO push and pop at cycle end
  assign o_fifo_push = dec_fifo && cyc_write_reg && o_ready;
  assign o_fifo_end_of_message = o_fifo_push && top_half;
  assign o_fifo_pop = dec_fifo && !cyc_write_reg && o_ready;

  // Diagnostic controls
  assign o_refresh_go = i_refresh_req &&
    !ctrl_reg[node_decode_pkg::CTL_REFRESH_DEFEAT];
  assign o_parity_enable = dec_dram &&
    !ctrl_reg[node_decode_pkg::CTL_FORCE_PARITY];
  assign o_tx_to_rx = i_tx_word_valid &&
    ctrl_reg[node_decode_pkg::CTL_WRAP];
  assign o_tx_to_net = i_tx_word_valid &&
    !ctrl_reg[node_decode_pkg::CTL_WRAP];

  // Masked interrupt, registered
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_irq <= 1'b0;
    else
      o_irq <= |(i_irq_src & irq_mask);
  end

  // Register read port, data one cycle after strobe
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_reg_rdata <= 32'h00000000;
    else if (i_reg_read)
    begin
      unique case (i_reg_addr)
        node_decode_pkg::REG_CTRL: o_reg_rdata <= {16'h0000, ctrl_reg};
        node_decode_pkg::REG_STATUS:
          o_reg_rdata <= {24'h000000, i_irq_src, 2'b00, state_reg};
        node_decode_pkg::REG_COUNT_LO: o_reg_rdata <= count[31:0];
        node_decode_pkg::REG_COUNT_HI:
          o_reg_rdata <= {8'h00, count[node_decode_pkg::COUNT_W-1:32]};
        default: o_reg_rdata <= 32'h00000000; // Unmapped reads zero
      endcase
    end
    else
      o_reg_rdata <= 32'h00000000;
  end

endmodule // node_address_decode
`default_nettype wire

/* File: node_decode_pkg.sv */
// Package of constants for the node address decode block.
// Assumes a single 10 MHz clock and a plain register port.
package node_decode_pkg;

  // Top-nibble block codes of the 4 GB space
  localparam logic [3:0] BLK_FIFO = 4'h3;
  localparam logic [3:0] BLK_STATUS = 4'h4;
  localparam logic [3:0] BLK_CTRL_COUNTER = 4'h5;
  localparam logic [3:0] BLK_SERIAL = 4'h6;
  localparam logic [3:0] BLK_DRAM_NC = 4'hD;
  localparam logic [3:0] BLK_DRAM = 4'hE;
  localparam logic [3:0] BLK_TOP = 4'hF;

  // Address bit positions
  localparam int TOP_HALF_BIT = 27;  // Upper half of a block
  localparam int EPROM_AW = 16;      // 64 KB EPROM alias
  localparam int DRAM_AW_SMALL = 23; // 8 MB DRAM repeat
  localparam int DRAM_AW_LARGE = 25; // 32 MB DRAM repeat

  // Control register field positions
  localparam int CTL_BOOT_OFF = 0;
  localparam int CTL_REFRESH_DEFEAT = 1;
  localparam int CTL_FORCE_PARITY = 2;
  localparam int CTL_WRAP = 3;
  localparam int CTL_MASK_LO = 8;
  localparam int CTL_MASK_W = 4;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Register offsets on the plain port (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT_LO = 4'h8;
  localparam logic [3:0] REG_COUNT_HI = 4'hC;

  // Counter timing
  localparam int CLOCK_NS = 100;
  localparam int COUNT_TICK_NS = 100;
  localparam int COUNT_TICK_CYC =
    (COUNT_TICK_NS / CLOCK_NS) < 1 ? 1 : (COUNT_TICK_NS / CLOCK_NS);
  localparam int COUNT_W = 56;

  // Write wait states for parity generation
  localparam int WRITE_WAITS = 1;

  // Bus cycle states
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_state_t;

endpackage : node_decode_pkg

/* File: node_tick_gen.sv */
// Tick divider for the free-running node counter.
// Assumes one clock; emits a one-cycle enable every period.
`timescale 1ns/1ps
`default_nettype none
module node_tick_gen
(
  input wire logic i_clock,  // System clock
  input wire logic i_reset,  // Async reset, high
  output logic o_tick        // One-cycle tick
);

  logic [7:0] div_reg; // Cycle counter

  // Divide clock to the tick rate
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      div_reg <= 8'h00;
      o_tick <= 1'b0;
    end
    else if (div_reg == 8'(node_decode_pkg::COUNT_TICK_CYC - 1))
    begin
      div_reg <= 8'h00;
      o_tick <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 8'h01;
      o_tick <= 1'b0;
    end
  end

endmodule // node_tick_gen
`default_nettype wire

/* File: node_counter.sv */
// Free-running node timer, advanced by an enable tick.
// Assumes the tick is a one-cycle pulse on i_clock.
`timescale 1ns/1ps
`default_nettype none
module node_counter
(
  input wire logic i_clock,  // System clock
  input wire logic i_reset,  // Async reset, high
  input wire logic i_tick,   // Advance enable
  output logic [node_decode_pkg::COUNT_W-1:0] o_count // Count value
);

  // Count one per tick, wrap at full width
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      o_count <= '0;
    else if (i_tick)
      o_count <= o_count + {{(node_decode_pkg::COUNT_W-1){1'b0}}, 1'b1};
  end

endmodule // node_counter
`default_nettype wire

/* File: node_decode_sva.sv */
// Port checker for the node address decode block.
// Bound into node_address_decode; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module node_decode_sva
(
  input wire logic i_clock,               // Clock
  input wire logic i_reset,               // Async reset
  input wire logic i_cpu_start,           // Cycle start
  input wire logic i_cpu_write,           // Write cycle
  input wire logic [31:0] i_cpu_addr,     // Address
  input wire logic [3:0] i_reg_addr,      // Register address
  input wire logic [31:0] i_reg_wdata,    // Register data
  input wire logic i_reg_write,           // Register write
  input wire logic [3:0] i_irq_src,       // Raw sources
  input wire logic i_tx_word_valid,       // Outgoing word
  input wire logic o_ready,               // Cycle end
  input wire logic o_sel_eprom,           // EPROM select
  input wire logic o_sel_dram,            // DRAM select
  input wire logic o_sel_fifo,            // FIFO select
  input wire logic o_sel_status,          // Status select
  input wire logic o_sel_ctrl_counter,    // Control select
  input wire logic o_sel_serial,          // Serial select
  input wire logic o_sel_none,            // No select
  input wire logic o_cache_allow_n,       // Cache enable
  input wire logic o_fifo_push,           // Push
  input wire logic o_fifo_end_of_message, // Push framing
  input wire logic o_fifo_pop,            // Pop
  input wire logic o_refresh_go,          // Refresh issue
  input wire logic o_parity_enable,       // Parity access
  input wire logic o_tx_to_rx,            // Loopback
  input wire logic o_irq                  // Interrupt
);
  logic busy_reg; // Cycle in flight
  logic [3:0] ctl_reg; // Shadow wrap, parity, refresh, boot
  logic [3:0] mask_reg; // Shadow interrupt mask
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Track one cycle at a time
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      busy_reg <= 1'b0;
    else if (o_ready)
      busy_reg <= 1'b0;
    else if (i_cpu_start)
      busy_reg <= 1'b1;
  end
  // Shadow of control bits; boot bit sticks until reset
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      ctl_reg <= 4'h0;
      mask_reg <= 4'h0;
    end
    else if (i_reg_write && i_reg_addr == node_decode_pkg::REG_CTRL)
    begin
      ctl_reg <= {i_reg_wdata[3:1], i_reg_wdata[0] | ctl_reg[0]};
      mask_reg <= i_reg_wdata[11:8];
    end
  end
  sequence taken;
    i_cpu_start && !busy_reg;
  endsequence
  sequence rd_taken;
    taken ##0 !i_cpu_write;
  endsequence
  sequence wr_taken;
    taken ##0 i_cpu_write;
  endsequence
  chk_read_answer: assert property (rd_taken |=> o_ready)
    else $error("read not answered next cycle");
  chk_write_wait: assert property (wr_taken |=> !o_ready ##1 o_ready)
    else $error("write wait state wrong");
  chk_one_driver: assert property ($onehot0({o_sel_eprom, o_sel_dram,
    o_sel_fifo, o_sel_status, o_sel_ctrl_counter, o_sel_serial, o_sel_none}))
    else $error("two selects at once");
  chk_boot_map: assert property (taken ##0 i_cpu_addr[31:27] == 5'h1F
    |=> o_sel_eprom != ctl_reg[0] && o_sel_dram == ctl_reg[0])
    else $error("top half block map wrong");
  chk_low_top: assert property (taken ##0 i_cpu_addr[31:27] == 5'h1E
    |=> o_sel_dram) else $error("low top half not DRAM");
  chk_dram_blocks: assert property (taken ##0
    i_cpu_addr[31:28] inside {4'hD, 4'hE} |=> o_sel_dram)
    else $error("DRAM block not selected");
  chk_no_cache: assert property (o_cache_allow_n ==
    (i_cpu_addr[31:28] == 4'hD)) else $error("cache allow wrong");
  chk_fifo_write: assert property (wr_taken ##0 i_cpu_addr[31:28] == 4'h3
    |=> ##1 o_fifo_push && o_fifo_end_of_message == $past(i_cpu_addr[27], 2))
    else $error("FIFO push wrong");
  chk_fifo_read: assert property (rd_taken ##0 i_cpu_addr[31:28] == 4'h3
    |=> o_fifo_pop && !o_fifo_push) else $error("FIFO pop wrong");
  chk_refresh_off: assert property (ctl_reg[1] |-> !o_refresh_go)
    else $error("refresh while defeated");
  chk_parity_off: assert property (ctl_reg[2] |-> !o_parity_enable)
    else $error("parity access while forced");
  chk_wrap_route: assert property (o_tx_to_rx ==
    (i_tx_word_valid && ctl_reg[3])) else $error("loopback route wrong");
  chk_irq_mask: assert property (o_irq ==
    |($past(i_irq_src) & $past(mask_reg))) else $error("masked irq wrong");
  chk_unused_none: assert property (taken ##0 !(i_cpu_addr[31:28] inside
    {[4'h3:4'h6], [4'hD:4'hF]}) |=> o_sel_none) else $error("unused selected");
endmodule // node_decode_sva

bind node_address_decode node_decode_sva i_sva (.*);
`default_nettype wire

/* File: node_cpu_model.sv */
// Host processor bus model issuing one memory cycle at a time.
// Assumes the block ends every cycle with a one-cycle ready.
`timescale 1ns/1ps
`default_nettype none
module node_cpu_model
(
  input wire logic i_clock,  // Bus clock
  input wire logic i_ready,  // Cycle complete
  output logic o_start,      // Start pulse
  output logic o_write,      // Write cycle
  output logic [31:0] o_addr // Address
);
  // Idle bus at time zero
  initial
  begin
    o_start = 1'b0;
    o_write = 1'b0;
    o_addr = 32'h0;
  end
  // One cycle; next start only after ready, address held till then
  task automatic run(input logic w, input logic [31:0] a, output int n);
  begin
    o_start <= 1'b1;
    o_write <= w;
    o_addr <= a;
    n = 0;
    @(posedge i_clock);
    o_start <= 1'b0;
    while (i_ready !== 1'b1 && n < 8)
    begin
      @(posedge i_clock);
      n++;
    end
    // Released lines stop showing the old cycle
    o_addr <= ~a;
    o_write <= ~w;
    // One edge between cycles, so no line is set twice at once
    @(posedge i_clock);
  end
  endtask
endmodule // node_cpu_model
`default_nettype wire

/* File: node_address_decode_tb.sv */
// Testbench for the node address decode block.
// Host model drives bus cycles; tasks drive the register port.
`timescale 1ns/1ps
`default_nettype none
module node_address_decode_tb;
  localparam logic [11:0] EP = 12'h800, DR = 12'h400, FI = 12'h200;
  localparam logic [11:0] ST = 12'h100, CC = 12'h080, SE = 12'h040;
  localparam logic [11:0] NO = 12'h020, PU = 12'h010, EM = 12'h008;
  localparam logic [11:0] PO = 12'h004, NC = 12'h002, PA = 12'h001;
  logic i_clock, i_reset, i_cpu_start, i_cpu_write, i_dram_large;
  logic i_refresh_req, i_tx_word_valid, i_reg_write, i_reg_read;
  logic [31:0] i_cpu_addr, i_reg_wdata, o_reg_rdata, d, c;
  logic [3:0] i_irq_src, i_reg_addr;
  logic o_ready, o_sel_eprom, o_sel_dram, o_sel_fifo, o_sel_status;
  logic o_sel_ctrl_counter, o_sel_serial, o_sel_none, o_cache_allow_n;
  logic o_fifo_push, o_fifo_end_of_message, o_fifo_pop, o_refresh_go;
  logic o_parity_enable, o_tx_to_net, o_tx_to_rx, o_irq;
  logic [15:0] o_eprom_addr, snap_e;
  logic [24:0] o_dram_addr, snap_d;
  logic [11:0] snap; // Outputs seen in the ready cycle
  int err_total = 0;
  int samples_checked = 0;
  node_address_decode i_dut (.*);
  node_cpu_model i_cpu (.i_clock(i_clock), .i_ready(o_ready),
    .o_start(i_cpu_start), .o_write(i_cpu_write), .o_addr(i_cpu_addr));
  // Clock, 100 ns period
  initial
  begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // Capture selects mid-cycle while ready stands
  always @(negedge i_clock)
    if (o_ready === 1'b1)
      snap = {o_sel_eprom, o_sel_dram, o_sel_fifo, o_sel_status,
        o_sel_ctrl_counter, o_sel_serial, o_sel_none, o_fifo_push,
        o_fifo_end_of_message, o_fifo_pop, o_cache_allow_n, o_parity_enable};
  always @(negedge i_clock)
    if (o_ready === 1'b1)
      {snap_e, snap_d} = {o_eprom_addr, o_dram_addr};
  task automatic chk(input string nm, input logic [31:0] e, g);
  begin
    samples_checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  end
  endtask
  // One bus cycle with latency and select check
  task automatic bus(input logic w, input logic [31:0] a, input logic [11:0] e);
    int n;
  begin
    snap = 'x;
    i_cpu.run(w, a, n);
    chk("latency", w ? 1 + node_decode_pkg::WRITE_WAITS : 1, n);
    chk("selects", {20'h0, e}, {20'h0, snap});
  end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
  begin
    {i_reg_write, i_reg_addr, i_reg_wdata} <= {1'b1, a, v};
    @(posedge i_clock);
    i_reg_write <= 1'b0;
  end
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
  begin
    {i_reg_read, i_reg_addr} <= {1'b1, a};
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    @(posedge i_clock);
    v = o_reg_rdata;
  end
  endtask
  task automatic wrap_up;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  // Watchdog far beyond the under one hundred cycles of the tests
  initial
  begin
    #500000;
    err_total++;
    wrap_up;
  end
  // Main sequence
  initial
  begin
    i_reset = 1'b1;
    {i_dram_large, i_tx_word_valid, i_reg_write, i_reg_read} = 4'h4;
    {i_reg_addr, i_irq_src, i_reg_wdata, i_refresh_req} = '1;
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b0;
    reg_rd(node_decode_pkg::REG_CTRL, d);
    chk("ctrl reset", 32'h0, d);
    bus(1'b0, 32'hF8012345, EP);
    chk("eprom offset", 32'h2345, {16'h0, snap_e});
    bus(1'b0, 32'hFFFF0000, EP);
    bus(1'b1, 32'hF7FFFFFC, DR | PA);
    bus(1'b0, 32'hE0812345, DR | PA);
    chk("dram 8M", 32'h12345, {9'h0, snap_d[22:0]});
    i_dram_large <= 1'b1;
    bus(1'b0, 32'hE2812345, DR | PA);
    chk("dram 32M", 32'h812345, {7'h0, snap_d});
    bus(1'b0, 32'hD0000010, DR | NC | PA);
    bus(1'b1, 32'h30000000, FI | PU);
    bus(1'b1, 32'h38000000, FI | PU | EM);
    bus(1'b0, 32'h30000004, FI | PO);
    bus(1'b0, 32'h3FFFFFFC, FI | PO);
    bus(1'b0, 32'h4ABCDEF0, ST);
    bus(1'b1, 32'h5FFFFFF0, CC);
    bus(1'b0, 32'h60000000, SE);
    bus(1'b0, 32'h00000000, NO);
    bus(1'b1, 32'h7FFFFFFC, NO);
    bus(1'b0, 32'hC0000000, NO);
    @(negedge i_clock);
    chk("refresh on", 32'h1, {31'h0, o_refresh_go});
    @(posedge i_clock);
    reg_wr(node_decode_pkg::REG_CTRL, 32'h00000003);
    @(negedge i_clock);
    chk("refresh off", 32'h0, {31'h0, o_refresh_go});
    @(posedge i_clock);
    bus(1'b0, 32'hF8000000, DR | PA);
    reg_wr(node_decode_pkg::REG_CTRL, 32'h00000004);
    bus(1'b0, 32'hFC000000, DR);
    reg_rd(node_decode_pkg::REG_CTRL, d);
    chk("boot sticky", 32'h5, d);
    chk("to net", 32'h2, {30'h0, o_tx_to_net, o_tx_to_rx});
    i_irq_src <= 4'h5;
    reg_wr(node_decode_pkg::REG_CTRL, 32'h00000409);
    @(posedge i_clock);
    @(negedge i_clock);
    chk("loopback", 32'h1, {30'h0, o_tx_to_net, o_tx_to_rx});
    chk("irq raised", 32'h1, {31'h0, o_irq});
    @(posedge i_clock);
    reg_wr(node_decode_pkg::REG_CTRL, 32'h00000A09);
    @(posedge i_clock);
    @(negedge i_clock);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    @(posedge i_clock);
    reg_rd(node_decode_pkg::REG_COUNT_LO, c);
    reg_rd(node_decode_pkg::REG_COUNT_LO, d);
    chk("count step", 32'h2, d - c);
    reg_wr(4'h2, 32'hFFFFFFFF);
    reg_rd(4'h2, d);
    chk("unmapped", 32'h0, d);
    // Mid-run reset maps the EPROM back in
    i_reset <= 1'b1;
    @(posedge i_clock);
    i_reset <= 1'b0;
    reg_rd(node_decode_pkg::REG_CTRL, d);
    chk("ctrl re-reset", 32'h0, d);
    bus(1'b0, 32'hF8000000, EP);
    wrap_up;
  end
endmodule // node_address_decode_tb
`default_nettype wire
